// ---- psg_top.sv ----
// module: pad config, strap capture and port data registers
module psg_top (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_sw_rst,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [13:0] i_port_dir,
  input wire logic [13:0] i_alt_sel,
  input wire logic [13:0] i_alt_out,
  input wire logic [13:0] i_pin_in,
  input wire logic [13:0] i_strap_low_pins,
  input wire logic [14:0] i_strap_high_pins,
  output logic [13:0] o_pin_out,
  output logic [13:0] o_pin_oe,
  output psg_pkg::psg_pad_ctrl_t o_pad_ctrl
);
  logic [15:0] pad_q, pad_d;
  logic [13:0] out_q, out_d;
  logic [13:0] sync1_q, sync2_q, in_q, in_d;
  logic [13:0] strap_lo_q, strap_lo_d;
  logic [14:0] strap_hi_q, strap_hi_d;
  logic [13:0] strap_lo_s1_q, strap_lo_s2_q;
  logic [14:0] strap_hi_s1_q, strap_hi_s2_q;
  logic strap_done_q;
  logic [15:0] rdata_q, rdata_d;

  // register select, shared by write and read decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  // next values of software registers; software reset clears them, not the straps
  always_comb
  begin
    pad_d = pad_q;
    out_d = out_q;
    if (i_sw_rst)
    begin
      pad_d = psg_pkg::MEDIA_PAD_RST;
      out_d = psg_pkg::PORT_OUT_RST;
    end
    else if (i_wr && hit(i_addr, psg_pkg::ADDR_MEDIA_PAD))
      pad_d = i_wdata & psg_pkg::MEDIA_PAD_MASK;
    else if (i_wr && hit(i_addr, psg_pkg::ADDR_PORT_OUT))
      out_d = i_wdata[13:0];
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pad_q <= psg_pkg::MEDIA_PAD_RST;
      out_q <= psg_pkg::PORT_OUT_RST;
    end
    else
    begin
      pad_q <= pad_d;
      out_q <= out_d;
    end
  end

  // register checks: reserved bits stay zero, both resets clear, idle cycles hold
  // (a stuck write enable shows up here long before a pad misbehaves)
  property p_pad_reserved;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |-> (pad_q & ~psg_pkg::MEDIA_PAD_MASK) == 16'h0000;
  endproperty
  a_pad_reserved: assert property (p_pad_reserved) else $error("reserved pad bit set");

  property p_hw_clear;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !$past(i_rstn) |-> out_q == psg_pkg::PORT_OUT_RST && pad_q == psg_pkg::MEDIA_PAD_RST;
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("data not cleared");

  property p_sw_clear;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_sw_rst |=> pad_q == psg_pkg::MEDIA_PAD_RST && out_q == psg_pkg::PORT_OUT_RST;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("sw reset left data set");

  property p_pad_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !(i_sw_rst || (i_wr && i_addr == psg_pkg::ADDR_MEDIA_PAD)) |=> $stable(pad_q);
  endproperty
  a_pad_hold: assert property (p_pad_hold) else $error("pad config changed unasked");

  property p_out_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !(i_sw_rst || (i_wr && i_addr == psg_pkg::ADDR_PORT_OUT)) |=> $stable(out_q);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output data changed unasked");

  // pad bank controls straight from the config register
  assign o_pad_ctrl.tx_pad_pullup_en = pad_q[psg_pkg::BIT_TX_PU];
  assign o_pad_ctrl.tx_pad_pulldown_en = pad_q[psg_pkg::BIT_TX_PD];
  assign o_pad_ctrl.rx_pad_pullup_en = pad_q[psg_pkg::BIT_RX_PU];
  assign o_pad_ctrl.rx_pad_pulldown_en = pad_q[psg_pkg::BIT_RX_PD];
  assign o_pad_ctrl.tx_pad_supply_sel = pad_q[psg_pkg::BIT_TX_VOL];
  assign o_pad_ctrl.rx_pad_supply_sel = pad_q[psg_pkg::BIT_RX_VOL];
  assign o_pad_ctrl.tx_data_slew_slow = pad_q[psg_pkg::BIT_TXD_SLEW];
  assign o_pad_ctrl.tx_clock_slew_slow = pad_q[psg_pkg::BIT_TXC_SLEW];
  assign o_pad_ctrl.rx_data_slew_slow = pad_q[psg_pkg::BIT_RXD_SLEW];
  assign o_pad_ctrl.rx_clock_slew_slow = pad_q[psg_pkg::BIT_RXC_SLEW];

  // receive-side fields checked one by one, so a swapped pair is caught
  property p_rx_pu;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.rx_pad_pullup_en == $past(i_wdata[9]);
  endproperty
  a_rx_pu: assert property (p_rx_pu) else $error("rx pullup not updated");

  property p_rx_vol;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.rx_pad_supply_sel == $past(i_wdata[4]);
  endproperty
  a_rx_vol: assert property (p_rx_vol) else $error("rx supply select wrong");

  property p_rx_slew;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.rx_data_slew_slow == $past(i_wdata[1]) &&
      o_pad_ctrl.rx_clock_slew_slow == $past(i_wdata[0]);
  endproperty
  a_rx_slew: assert property (p_rx_slew) else $error("rx slew select wrong");

  // per-pin mux: alternate function or gpio output, direction gates enable
  genvar g;
  generate
    for (g = 0; g < psg_pkg::PORT_W; g++)
    begin : g_pin
      assign o_pin_out[g] = i_alt_sel[g] ? i_alt_out[g] : out_q[g];
      assign o_pin_oe[g] = i_port_dir[g];
    end
  endgenerate

  // pin checks: mux select and direction pass straight through
  property p_pin_mux;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |-> ((o_pin_out ^ i_alt_out) & i_alt_sel) == 14'h0000 &&
      ((o_pin_out ^ out_q) & ~i_alt_sel) == 14'h0000;
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin source wrong");

  property p_pin_dir;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |-> o_pin_oe == i_port_dir;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");

  // pin levels: two-flop synchroniser then latched copy for reads
  always_comb
  begin
    in_d = sync2_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_q <= psg_pkg::PORT_IN_RST;
      sync2_q <= psg_pkg::PORT_IN_RST;
      in_q <= psg_pkg::PORT_IN_RST;
    end
    else
    begin
      sync1_q <= i_pin_in;
      sync2_q <= sync1_q;
      in_q <= in_d;
    end
  end

  // strap pins are asynchronous: two stages before capture; no reset, so they
  // keep sampling while hardware reset is held. limitation: straps must be
  // steady for two clocks before release, which any strap board gives
  always_ff @(posedge i_ref_clk)
  begin
    strap_lo_s1_q <= i_strap_low_pins;
    strap_lo_s2_q <= strap_lo_s1_q;
    strap_hi_s1_q <= i_strap_high_pins;
    strap_hi_s2_q <= strap_hi_s1_q;
  end

  // straps: taken on the first clock after hardware reset release, since an
  // async reset may only load constants; software reset never touches them
  always_comb
  begin
    strap_lo_d = strap_lo_q;
    strap_hi_d = strap_hi_q;
    if (!strap_done_q)
    begin
      strap_lo_d = strap_lo_s2_q;
      strap_hi_d = strap_hi_s2_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      strap_done_q <= 1'b0;
    else
      strap_done_q <= 1'b1;
  end

  // no reset: strap contents are undefined until latched
  always_ff @(posedge i_ref_clk)
  begin
    strap_lo_q <= strap_lo_d;
    strap_hi_q <= strap_hi_d;
  end

  // capture checked against the pins three edges back: two sync stages and the latch
  property p_strap_lo_cap;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !strap_done_q |=> strap_lo_q == $past(i_strap_low_pins, 3);
  endproperty
  a_strap_lo_cap: assert property (p_strap_lo_cap) else $error("strap low lost");

  property p_strap_hi_cap;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !strap_done_q |=> strap_hi_q == $past(i_strap_high_pins, 3);
  endproperty
  a_strap_hi_cap: assert property (p_strap_hi_cap) else $error("strap high lost");

  // read mux; unmapped addresses read zero, data one cycle after strobe
  always_comb
  begin
    rdata_d = 16'h0000;
    if (i_rd)
    begin
      if (hit(i_addr, psg_pkg::ADDR_MEDIA_PAD))
        rdata_d = pad_q;
      else if (hit(i_addr, psg_pkg::ADDR_PORT_OUT))
        rdata_d = {2'h0, out_q};
      else if (hit(i_addr, psg_pkg::ADDR_PORT_IN))
        rdata_d = {2'h0, in_q};
      else if (hit(i_addr, psg_pkg::ADDR_STRAP_LOW))
        rdata_d = {2'h0, strap_lo_q};
      else if (hit(i_addr, psg_pkg::ADDR_STRAP_HIGH))
        rdata_d = {1'h0, strap_hi_q};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;

  // read path: each mapped register comes back the cycle after its strobe, else zero
  property p_read_pad;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=> o_rdata == $past(pad_q);
  endproperty
  a_read_pad: assert property (p_read_pad) else $error("pad config read wrong");

  property p_read_out;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && i_addr == psg_pkg::ADDR_PORT_OUT) |=> o_rdata == {2'h0, $past(out_q)};
  endproperty
  a_read_out: assert property (p_read_out) else $error("output data read wrong");

  property p_read_strap_lo;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && i_addr == psg_pkg::ADDR_STRAP_LOW) |=> o_rdata == {2'h0, $past(strap_lo_q)};
  endproperty
  a_read_strap_lo: assert property (p_read_strap_lo) else $error("strap read wrong");

  property p_read_strap_hi;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && i_addr == psg_pkg::ADDR_STRAP_HIGH) |=> o_rdata == {1'h0, $past(strap_hi_q)};
  endproperty
  a_read_strap_hi: assert property (p_read_strap_hi) else $error("strap read wrong");

  property p_read_idle;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");

  // checks
  property p_tx_pu;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.tx_pad_pullup_en == $past(i_wdata[11]);
  endproperty
  a_tx_pu: assert property (p_tx_pu) else $error("tx pullup not updated");

  property p_rx_pd;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.rx_pad_pulldown_en == $past(i_wdata[8]) &&
      o_pad_ctrl.tx_pad_pulldown_en == $past(i_wdata[10]);
  endproperty
  a_rx_pd: assert property (p_rx_pd) else $error("pulldown not updated");

  property p_vol;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      o_pad_ctrl.tx_pad_supply_sel == $past(i_wdata[5]) &&
      o_pad_ctrl.rx_pad_supply_sel == $past(i_wdata[4]);
  endproperty
  a_vol: assert property (p_vol) else $error("supply select wrong");

  property p_slew;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_MEDIA_PAD) |=>
      {o_pad_ctrl.tx_data_slew_slow, o_pad_ctrl.tx_clock_slew_slow,
       o_pad_ctrl.rx_data_slew_slow, o_pad_ctrl.rx_clock_slew_slow} == $past(i_wdata[3:0]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew select wrong");

  property p_strap_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    strap_done_q |=> $stable(strap_lo_q) && $stable(strap_hi_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_out_drive;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_wr && !i_sw_rst && i_addr == psg_pkg::ADDR_PORT_OUT) |=>
      ((o_pin_out ^ $past(i_wdata[13:0])) & ~i_alt_sel) == 14'h0000 &&
      out_q == $past(i_wdata[13:0]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output data wrong");

  property p_sync;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $past(i_rstn, 3) |-> in_q == $past(i_pin_in, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("input latency wrong");

  property p_in_read;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && i_addr == psg_pkg::ADDR_PORT_IN) |=> o_rdata == {2'h0, $past(in_q)};
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read wrong");

  property p_swrst;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_sw_rst |=> out_q == 14'h0000 && $stable(strap_lo_q);
  endproperty
  a_swrst: assert property (p_swrst) else $error("sw reset effect wrong");
endmodule // psg_top

// ---- psg_pkg.sv ----
// package: register map, field positions and reset values for the pad/strap/port block
package psg_pkg;
  // register offsets; media pad config offset fa78, strap low offset chosen as fa80
  localparam logic [15:0] ADDR_PORT_OUT = 16'hf380;
  localparam logic [15:0] ADDR_PORT_IN = 16'hf381;
  localparam logic [15:0] ADDR_MEDIA_PAD = 16'hfa78;
  localparam logic [15:0] ADDR_STRAP_LOW = 16'hfa80;
  localparam logic [15:0] ADDR_STRAP_HIGH = 16'hfa81;

  // media pad config field positions
  localparam int BIT_TX_PU = 11;
  localparam int BIT_TX_PD = 10;
  localparam int BIT_RX_PU = 9;
  localparam int BIT_RX_PD = 8;
  localparam int BIT_TX_VOL = 5;
  localparam int BIT_RX_VOL = 4;
  localparam int BIT_TXD_SLEW = 3;
  localparam int BIT_TXC_SLEW = 2;
  localparam int BIT_RXD_SLEW = 1;
  localparam int BIT_RXC_SLEW = 0;
  localparam logic [15:0] MEDIA_PAD_MASK = 16'h0f3f;

  // widths and reset values
  localparam int PORT_W = 14;
  localparam int STRAP_HI_W = 15;
  localparam logic [15:0] MEDIA_PAD_RST = 16'h0000;
  localparam logic [13:0] PORT_OUT_RST = 14'h0000;
  localparam logic [13:0] PORT_DIR_RST = 14'h0000;
  localparam logic [13:0] PORT_IN_RST = 14'h0000;

  // pad control bundle forwarded to the media pad bank
  typedef struct packed {
    logic tx_pad_pullup_en;
    logic tx_pad_pulldown_en;
    logic rx_pad_pullup_en;
    logic rx_pad_pulldown_en;
    logic tx_pad_supply_sel;
    logic rx_pad_supply_sel;
    logic tx_data_slew_slow;
    logic tx_clock_slew_slow;
    logic rx_data_slew_slow;
    logic rx_clock_slew_slow;
  } psg_pad_ctrl_t;
endpackage

// ---- psg_top_test.sv ----
// testbench: register bus, pad control, strap capture and port data checks for psg_top
module psg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_rstn, i_sw_rst, i_wr, i_rd;
  logic [15:0] i_addr, i_wdata, o_rdata, q;
  logic [13:0] i_port_dir, i_alt_sel, i_alt_out, i_pin_in;
  logic [13:0] i_strap_low_pins, o_pin_out, o_pin_oe;
  logic [14:0] i_strap_high_pins;
  psg_pkg::psg_pad_ctrl_t o_pad_ctrl;
  int bad_count = 0;
  int tests_run = 0;

  psg_top DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sw_rst(i_sw_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_dir(i_port_dir),
    .i_alt_sel(i_alt_sel), .i_alt_out(i_alt_out), .i_pin_in(i_pin_in),
    .i_strap_low_pins(i_strap_low_pins), .i_strap_high_pins(i_strap_high_pins),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pad_ctrl(o_pad_ctrl));

  // 20 mhz reference clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus cycles: strobes one cycle wide, read data sampled once the answer edge has landed
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask

  // hardware reset held 8 cycles; straps settle on the first edge after release
  task automatic hw_reset();
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic t_reset();
    rd(psg_pkg::ADDR_MEDIA_PAD);
    chk(q, 16'h0000);
    rd(psg_pkg::ADDR_PORT_OUT);
    chk(q, 16'h0000);
    chk({2'h0, o_pin_out}, 16'h0000);
    rd(psg_pkg::ADDR_STRAP_LOW);
    chk(q, 16'h2d3c);
    rd(psg_pkg::ADDR_STRAP_HIGH);
    chk(q, 16'h5a1b);
  endtask

  // walk a single one through all sixteen bits; only the ten field bits stick
  task automatic t_pad();
    logic [15:0] d;
    for (int i = 0; i < 16; i++)
    begin
      d = 16'h0001 << i;
      wr(psg_pkg::ADDR_MEDIA_PAD, d);
      chk({6'h00, o_pad_ctrl}, {6'h00, d[11:8], d[5:0]});
      rd(psg_pkg::ADDR_MEDIA_PAD);
      chk(q, d & 16'h0f3f);
    end
  endtask

  task automatic t_port();
    @(posedge i_ref_clk);
    i_port_dir <= 14'h1555;
    wr(psg_pkg::ADDR_PORT_OUT, 16'h2a55);
    chk({2'h0, o_pin_out}, 16'h2a55);
    chk({2'h0, o_pin_oe}, 16'h1555);
    rd(psg_pkg::ADDR_PORT_OUT);
    chk(q, 16'h2a55);
    wr(psg_pkg::ADDR_PORT_OUT, 16'hffff);
    rd(psg_pkg::ADDR_PORT_OUT);
    chk(q, 16'h3fff);
    @(posedge i_ref_clk);
    i_alt_sel <= 14'h00ff;
    i_alt_out <= 14'h000f;
    @(posedge i_ref_clk);
    #1;
    chk({2'h0, o_pin_out}, 16'h3f0f);
  endtask

  // pins need the synchroniser stages before they reach the input register
  task automatic t_in();
    @(posedge i_ref_clk);
    i_pin_in <= 14'h1234;
    repeat (4) @(posedge i_ref_clk);
    rd(psg_pkg::ADDR_PORT_IN);
    chk(q, 16'h1234);
    wr(psg_pkg::ADDR_PORT_IN, 16'h0000);
    rd(psg_pkg::ADDR_PORT_IN);
    chk(q, 16'h1234);
  endtask

  // software reset clears config and data but must leave the strap snapshot alone
  task automatic t_sw();
    wr(psg_pkg::ADDR_MEDIA_PAD, 16'h0f3f);
    @(posedge i_ref_clk);
    i_strap_low_pins <= 14'h12c3;
    i_strap_high_pins <= 15'h25e4;
    i_sw_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_sw_rst <= 1'b0;
    rd(psg_pkg::ADDR_MEDIA_PAD);
    chk(q, 16'h0000);
    rd(psg_pkg::ADDR_PORT_OUT);
    chk(q, 16'h0000);
    wr(psg_pkg::ADDR_STRAP_LOW, 16'hffff);
    rd(psg_pkg::ADDR_STRAP_LOW);
    chk(q, 16'h2d3c);
    rd(psg_pkg::ADDR_STRAP_HIGH);
    chk(q, 16'h5a1b);
    rd(16'h1234);
    chk(q, 16'h0000);
    hw_reset();
    rd(psg_pkg::ADDR_STRAP_LOW);
    chk(q, 16'h12c3);
    rd(psg_pkg::ADDR_STRAP_HIGH);
    chk(q, 16'h25e4);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {i_rstn, i_sw_rst, i_wr, i_rd} = 4'h0;
    {i_addr, i_wdata} = 32'h0;
    {i_port_dir, i_alt_sel, i_alt_out, i_pin_in} = 56'h0;
    i_strap_low_pins = 14'h2d3c;
    i_strap_high_pins = 15'h5a1b;
    hw_reset();
    t_reset();
    t_pad();
    t_port();
    t_in();
    t_sw();
    complete_run();
  end

  // watchdog: the sequence needs about 136 cycles, allow some 4000
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule // psg_top_test
